// File: rtl/cod_decoder.sv
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
// Contract
// - 8e moves into a segment register, 8c out; selector preceded by zero bit.
// - Byte d7 is table_lookup_byte, a single-byte instruction.
// - 8d plus operand byte is effective_address_load.
// - c5 and c4 plus operand byte load pointer with data or extra segment.
// - 9f, 9e and 9c: flags to high acc, high acc to flags, push flags.
// - 000000dw plus operand byte is sum_op; flow bit 1, size bit 0.
// - sum_with_carry_op: 000100dw, group select 010, accumulator form 0001010w.
// - difference_op: 001010dw, group select 101, accumulator form 0010110w.
// - difference_with_borrow_op: 000110dw, group select 011, accumulator 0001110w.
// - Byte 37 is bcd_unpacked_sum_fix.
// - Byte 27 is bcd_packed_sum_fix.
// - Byte 3f is bcd_unpacked_diff_fix.
// - Byte 2f is bcd_packed_diff_fix.
// - Under 1111011w, select 101 gives signed_product.
// - Under 1111011w, select 111 gives signed_quotient.
// - Bytes d4 then 0a give bcd_unpacked_product_fix.
// - Bytes d5 then 0a give bcd_unpacked_quotient_prep.
// - Byte 98 is byte_to_word_widen.
// - Byte 99 is word_to_pair_widen.
// - 110100vw with select 100 is left_shift; amount bit 1, size bit 0.
// - 110100vw with select 101 is logical right_shift.
module cod_decoder
    import cod_pkg::*;
#(
    parameter int ADDR_W = COD_ADDR_W
)(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [7:0] q_byte_in,
    input wire logic q_valid_in,
    output logic q_ready_out,
    output logic dec_valid_out,
    output logic [COD_RES_W-1:0] dec_result_out
);

    typedef struct packed {
        cod_state_type st;
        logic [7:0] b0;
        logic [7:0] b1;
        cod_op_type op;
        logic flow;
        logic size;
        logic ext;
        logic amt;
        logic [1:0] disp_left;
        logic [1:0] imm_left;
        logic imm_hi;
        logic [15:0] imm;
        logic [2:0] length;
        cod_result_type res;
        logic valid;
        logic ready;
        logic enable;
        logic done;
        logic [7:0] count;
        logic wait_r;
        logic [31:0] rdata;
    } cod_top_type;

    localparam cod_result_type RES_RST = '{
        op: OP_UNKNOWN,
        default: '0
    };

    localparam cod_top_type TOP_RST = '{
        st: ST_IDLE,
        op: OP_UNKNOWN,
        res: RES_RST,
        enable: CTRL_ENABLE_RST,
        ready: CTRL_ENABLE_RST,
        count: COUNT_RST,
        wait_r: 1'b1,
        default: '0
    };

    cod_top_type s_ff;
    cod_top_type nxt_s;
    cod_dec_if dif();

    // Second byte always comes straight off the queue
    assign dif.b0 = (s_ff.st == ST_IDLE) ? q_byte_in : s_ff.b0;
    assign dif.b1 = q_byte_in;

    cod_first_stage u_first (
        .dif(dif)
    );

    cod_second_stage u_second (
        .dif(dif)
    );

    function automatic cod_result_type build_res(input cod_top_type t);
        cod_result_type r;
        r = RES_RST;
        r.op = t.op;
        r.illegal = (t.op == OP_UNKNOWN);
        r.length = t.length;
        r.size_flag = t.size;
        r.extend_bit = t.ext;
        r.amount_bit = t.amt;
        r.reg_is_dest = t.flow;
        r.mode = t.b1[7:6];
        r.reg_field = t.b1[5:3];
        r.rm = t.b1[2:0];
        if (!t.size) begin
            r.imm = {8'h00, t.imm[7:0]};
        end else if (t.ext) begin
            r.imm = {{8{t.imm[7]}}, t.imm[7:0]};
        end else begin
            r.imm = t.imm;
        end
        if (t.op == OP_LEFT_SHIFT || t.op == OP_RIGHT_SHIFT) begin
            r.shift_count = t.amt ? t.count : SHIFT_ONE;
        end else begin
            r.shift_count = 8'h00;
        end
        return r;
    endfunction

    logic accept;
    logic hit;
    logic wr_go;
    logic fin;
    logic clr_dec;
    logic clr_done;
    logic [2:0] rem;
    logic [63:0] res_wide;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.valid = 1'b0;
        fin = 1'b0;
        clr_dec = 1'b0;
        clr_done = 1'b0;
        accept = q_valid_in & s_ff.ready;
        rem = {1'b0, s_ff.disp_left} + {1'b0, s_ff.imm_left};
        res_wide = 64'(s_ff.res);

        // One wait cycle per access; the effect lands on the accepting edge
        hit = (avs_read_in | avs_write_in) & s_ff.wait_r;
        wr_go = avs_write_in & ~s_ff.wait_r;
        nxt_s.wait_r = ~hit;
        if (hit && avs_read_in) begin
            case (avs_address_in)
                REG_CTRL: nxt_s.rdata = {31'h0, s_ff.enable};
                REG_STATUS: nxt_s.rdata = {28'h0, s_ff.st, s_ff.st != ST_IDLE, s_ff.done};
                REG_COUNT: nxt_s.rdata = {24'h0, s_ff.count};
                REG_RES_LO: nxt_s.rdata = res_wide[31:0];
                REG_RES_HI: nxt_s.rdata = res_wide[63:32];
                default: nxt_s.rdata = 32'h0;
            endcase
        end
        if (wr_go && avs_byteenable_in[0]) begin
            case (avs_address_in)
                REG_CTRL: begin
                    nxt_s.enable = avs_writedata_in[CTRL_ENABLE_BIT];
                    clr_dec = avs_writedata_in[CTRL_CLEAR_BIT];
                end
                REG_STATUS: clr_done = avs_writedata_in[STAT_DONE_BIT];
                REG_COUNT: nxt_s.count = avs_writedata_in[7:0];
                default: clr_dec = 1'b0;
            endcase
        end
        nxt_s.ready = nxt_s.enable;

        if (clr_dec) begin
            // A byte taken in the clearing cycle is dropped
            nxt_s.st = ST_IDLE;
            nxt_s.length = 3'd0;
        end else if (accept) begin
            nxt_s.length = s_ff.length + 3'd1;
            case (s_ff.st)
                ST_IDLE: begin
                    nxt_s.b0 = q_byte_in;
                    nxt_s.b1 = 8'h00;
                    nxt_s.op = dif.first_op;
                    nxt_s.flow = dif.flow_flag;
                    nxt_s.size = dif.size_flag;
                    nxt_s.ext = dif.extend_bit;
                    nxt_s.amt = dif.amount_bit;
                    nxt_s.length = 3'd1;
                    nxt_s.disp_left = 2'd0;
                    nxt_s.imm_left = dif.imm_len;
                    nxt_s.imm_hi = 1'b0;
                    nxt_s.imm = 16'h0000;
                    case (dif.form)
                        FORM_SINGLE: fin = 1'b1;
                        FORM_ACC_IMM: nxt_s.st = ST_REST;
                        default: nxt_s.st = ST_MODRM;
                    endcase
                end
                ST_MODRM: begin
                    nxt_s.b1 = q_byte_in;
                    nxt_s.op = dif.op;
                    nxt_s.disp_left = dif.disp_len;
                    if (dif.disp_len == 2'd0 && s_ff.imm_left == 2'd0) begin
                        fin = 1'b1;
                    end else begin
                        nxt_s.st = ST_REST;
                    end
                end
                ST_REST: begin
                    if (s_ff.disp_left != 2'd0) begin
                        nxt_s.disp_left = s_ff.disp_left - 2'd1;
                    end else begin
                        nxt_s.imm_left = s_ff.imm_left - 2'd1;
                        nxt_s.imm_hi = 1'b1;
                        if (s_ff.imm_hi) begin
                            nxt_s.imm[15:8] = q_byte_in;
                        end else begin
                            nxt_s.imm[7:0] = q_byte_in;
                        end
                    end
                    fin = (rem == 3'd1);
                end
                default: nxt_s.st = ST_IDLE;
            endcase
        end

        if (fin) begin
            nxt_s.st = ST_IDLE;
            nxt_s.res = build_res(nxt_s);
            nxt_s.valid = 1'b1;
        end
        // New completion beats a software clear in the same cycle
        nxt_s.done = (s_ff.done & ~clr_done) | fin;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            s_ff <= TOP_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign avs_readdata_out = s_ff.rdata;
    assign avs_waitrequest_out = s_ff.wait_r;
    assign q_ready_out = s_ff.ready;
    assign dec_valid_out = s_ff.valid;
    assign dec_result_out = s_ff.res;

endmodule

// File: rtl/cod_pkg.sv
package cod_pkg;

    // Register map, byte addresses, one aligned word each
    localparam int COD_ADDR_W = 5;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_COUNT = 5'h08;
    localparam logic [4:0] REG_RES_LO = 5'h0c;
    localparam logic [4:0] REG_RES_HI = 5'h10;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int STAT_DONE_BIT = 0;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] SHIFT_ONE = 8'h01;

    // Whole first bytes, plus the fixed second byte 0a
    localparam logic [7:0] OPC_SEG_LOAD = 8'h8e;
    localparam logic [7:0] OPC_SEG_STORE = 8'h8c;
    localparam logic [7:0] OPC_TABLE_LOOKUP = 8'hd7;
    localparam logic [7:0] OPC_EA_LOAD = 8'h8d;
    localparam logic [7:0] OPC_PTR_DATA = 8'hc5;
    localparam logic [7:0] OPC_PTR_EXTRA = 8'hc4;
    localparam logic [7:0] OPC_FLAGS_TO_AH = 8'h9f;
    localparam logic [7:0] OPC_AH_TO_FLAGS = 8'h9e;
    localparam logic [7:0] OPC_FLAGS_PUSH = 8'h9c;
    localparam logic [7:0] OPC_BCD_U_SUM = 8'h37;
    localparam logic [7:0] OPC_BCD_P_SUM = 8'h27;
    localparam logic [7:0] OPC_BCD_U_DIFF = 8'h3f;
    localparam logic [7:0] OPC_BCD_P_DIFF = 8'h2f;
    localparam logic [7:0] OPC_BCD_U_PROD = 8'hd4;
    localparam logic [7:0] OPC_BCD_U_QUOT = 8'hd5;
    localparam logic [7:0] OPC_FIXED_B1 = 8'h0a;
    localparam logic [7:0] OPC_WIDEN_BYTE = 8'h98;
    localparam logic [7:0] OPC_WIDEN_WORD = 8'h99;

    // Patterns on upper bits of the first byte
    localparam logic [5:0] PAT_SUM_REG = 6'h00;
    localparam logic [5:0] PAT_CARRY_REG = 6'h04;
    localparam logic [5:0] PAT_DIFF_REG = 6'h0a;
    localparam logic [5:0] PAT_BORROW_REG = 6'h06;
    localparam logic [6:0] PAT_SUM_ACC = 7'h02;
    localparam logic [6:0] PAT_CARRY_ACC = 7'h0a;
    localparam logic [6:0] PAT_DIFF_ACC = 7'h16;
    localparam logic [6:0] PAT_BORROW_ACC = 7'h0e;
    localparam logic [5:0] PAT_IMM_GROUP = 6'h20;
    localparam logic [6:0] PAT_UNARY_GROUP = 7'h7b;
    localparam logic [5:0] PAT_SHIFT_GROUP = 6'h34;

    // Select field of the operand-specifier byte
    localparam logic [2:0] SEL_SUM = 3'h0;
    localparam logic [2:0] SEL_CARRY = 3'h2;
    localparam logic [2:0] SEL_BORROW = 3'h3;
    localparam logic [2:0] SEL_DIFF = 3'h5;
    localparam logic [2:0] SEL_SPRODUCT = 3'h5;
    localparam logic [2:0] SEL_SQUOTIENT = 3'h7;
    localparam logic [2:0] SEL_LSHIFT = 3'h4;
    localparam logic [2:0] SEL_RSHIFT = 3'h5;

    typedef enum logic [4:0] {
        OP_UNKNOWN, OP_SEG_LOAD, OP_SEG_STORE, OP_TABLE_LOOKUP_BYTE,
        OP_EFFECTIVE_ADDRESS_LOAD, OP_POINTER_LOAD_DATA_SEG, OP_POINTER_LOAD_EXTRA_SEG,
        OP_FLAGS_TO_HIGH_ACC, OP_HIGH_ACC_TO_FLAGS, OP_FLAGS_PUSH,
        OP_SUM, OP_SUM_WITH_CARRY, OP_DIFFERENCE, OP_DIFFERENCE_WITH_BORROW,
        OP_BCD_UNPACKED_SUM_FIX, OP_BCD_PACKED_SUM_FIX, OP_BCD_UNPACKED_DIFF_FIX,
        OP_BCD_PACKED_DIFF_FIX, OP_SIGNED_PRODUCT, OP_SIGNED_QUOTIENT,
        OP_BCD_UNPACKED_PRODUCT_FIX, OP_BCD_UNPACKED_QUOTIENT_PREP,
        OP_BYTE_TO_WORD_WIDEN, OP_WORD_TO_PAIR_WIDEN, OP_LEFT_SHIFT, OP_RIGHT_SHIFT
    } cod_op_type;

    typedef enum logic [2:0] {
        FORM_SINGLE, FORM_MODRM, FORM_IMM_GROUP, FORM_ACC_IMM,
        FORM_UNARY_GROUP, FORM_SHIFT, FORM_FIXED_B1
    } cod_form_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MODRM = 2'b01,
        ST_REST = 2'b11
    } cod_state_type;

    typedef struct packed {
        logic illegal;
        logic [2:0] length;
        logic [7:0] shift_count;
        logic [15:0] imm;
        logic [2:0] rm;
        logic [1:0] mode;
        logic [2:0] reg_field;
        logic reg_is_dest;
        logic amount_bit;
        logic extend_bit;
        logic size_flag;
        cod_op_type op;
    } cod_result_type;

    localparam int COD_RES_W = $bits(cod_result_type);

endpackage

// File: rtl/cod_dec_if.sv
`timescale 1ns/100ps
interface cod_dec_if;
    import cod_pkg::*;
    logic [7:0] b0;
    logic [7:0] b1;
    cod_form_type form;
    cod_op_type first_op;
    logic [1:0] imm_len;
    logic flow_flag;
    logic size_flag;
    logic extend_bit;
    logic amount_bit;
    cod_op_type op;
    logic [1:0] disp_len;

    modport first_mp (input b0, output form, first_op, imm_len, flow_flag, size_flag,
        extend_bit, amount_bit);
    modport second_mp (input b1, form, first_op, output op, disp_len);
    modport top_mp (output b0, b1, input form, first_op, imm_len, flow_flag, size_flag,
        extend_bit, amount_bit, op, disp_len);
endinterface

// File: rtl/cod_first_stage.sv
`timescale 1ns/100ps
module cod_first_stage
    import cod_pkg::*;
(
    cod_dec_if.first_mp dif
);

    always_comb begin
        dif.form = FORM_SINGLE;
        dif.first_op = OP_UNKNOWN;
        dif.imm_len = 2'd0;
        dif.flow_flag = 1'b0;
        dif.size_flag = 1'b0;
        dif.extend_bit = 1'b0;
        dif.amount_bit = 1'b0;
        case (dif.b0)
            OPC_SEG_LOAD: begin
                dif.form = FORM_MODRM;
                dif.first_op = OP_SEG_LOAD;
            end
            OPC_SEG_STORE: begin
                dif.form = FORM_MODRM;
                dif.first_op = OP_SEG_STORE;
            end
            OPC_EA_LOAD: begin
                dif.form = FORM_MODRM;
                dif.first_op = OP_EFFECTIVE_ADDRESS_LOAD;
            end
            OPC_PTR_DATA: begin
                dif.form = FORM_MODRM;
                dif.first_op = OP_POINTER_LOAD_DATA_SEG;
            end
            OPC_PTR_EXTRA: begin
                dif.form = FORM_MODRM;
                dif.first_op = OP_POINTER_LOAD_EXTRA_SEG;
            end
            OPC_BCD_U_PROD: begin
                dif.form = FORM_FIXED_B1;
                dif.first_op = OP_BCD_UNPACKED_PRODUCT_FIX;
            end
            OPC_BCD_U_QUOT: begin
                dif.form = FORM_FIXED_B1;
                dif.first_op = OP_BCD_UNPACKED_QUOTIENT_PREP;
            end
            OPC_TABLE_LOOKUP: dif.first_op = OP_TABLE_LOOKUP_BYTE;
            OPC_FLAGS_TO_AH: dif.first_op = OP_FLAGS_TO_HIGH_ACC;
            OPC_AH_TO_FLAGS: dif.first_op = OP_HIGH_ACC_TO_FLAGS;
            OPC_FLAGS_PUSH: dif.first_op = OP_FLAGS_PUSH;
            OPC_BCD_U_SUM: dif.first_op = OP_BCD_UNPACKED_SUM_FIX;
            OPC_BCD_P_SUM: dif.first_op = OP_BCD_PACKED_SUM_FIX;
            OPC_BCD_U_DIFF: dif.first_op = OP_BCD_UNPACKED_DIFF_FIX;
            OPC_BCD_P_DIFF: dif.first_op = OP_BCD_PACKED_DIFF_FIX;
            OPC_WIDEN_BYTE: dif.first_op = OP_BYTE_TO_WORD_WIDEN;
            OPC_WIDEN_WORD: dif.first_op = OP_WORD_TO_PAIR_WIDEN;
            default: begin
                dif.size_flag = dif.b0[0];
                if (dif.b0[7:2] == PAT_SUM_REG || dif.b0[7:2] == PAT_CARRY_REG ||
                    dif.b0[7:2] == PAT_DIFF_REG || dif.b0[7:2] == PAT_BORROW_REG) begin
                    dif.form = FORM_MODRM;
                    dif.flow_flag = dif.b0[1];
                    case (dif.b0[7:2])
                        PAT_SUM_REG: dif.first_op = OP_SUM;
                        PAT_CARRY_REG: dif.first_op = OP_SUM_WITH_CARRY;
                        PAT_DIFF_REG: dif.first_op = OP_DIFFERENCE;
                        default: dif.first_op = OP_DIFFERENCE_WITH_BORROW;
                    endcase
                end else if (dif.b0[7:2] == PAT_IMM_GROUP) begin
                    dif.form = FORM_IMM_GROUP;
                    dif.extend_bit = dif.b0[1];
                    // Extended byte immediate carries one data byte only
                    dif.imm_len = (dif.b0[0] && !dif.b0[1]) ? 2'd2 : 2'd1;
                end else if (dif.b0[7:1] == PAT_UNARY_GROUP) begin
                    dif.form = FORM_UNARY_GROUP;
                end else if (dif.b0[7:2] == PAT_SHIFT_GROUP) begin
                    dif.form = FORM_SHIFT;
                    dif.amount_bit = dif.b0[1];
                end else if (dif.b0[7:1] == PAT_SUM_ACC || dif.b0[7:1] == PAT_CARRY_ACC ||
                    dif.b0[7:1] == PAT_DIFF_ACC || dif.b0[7:1] == PAT_BORROW_ACC) begin
                    dif.form = FORM_ACC_IMM;
                    dif.imm_len = dif.b0[0] ? 2'd2 : 2'd1;
                    case (dif.b0[7:1])
                        PAT_SUM_ACC: dif.first_op = OP_SUM;
                        PAT_CARRY_ACC: dif.first_op = OP_SUM_WITH_CARRY;
                        PAT_DIFF_ACC: dif.first_op = OP_DIFFERENCE;
                        default: dif.first_op = OP_DIFFERENCE_WITH_BORROW;
                    endcase
                end else begin
                    dif.size_flag = 1'b0;
                end
            end
        endcase
    end

endmodule

// File: rtl/cod_second_stage.sv
`timescale 1ns/100ps
module cod_second_stage
    import cod_pkg::*;
(
    cod_dec_if.second_mp dif
);

    always_comb begin
        dif.op = OP_UNKNOWN;
        case (dif.b1[7:6])
            2'b00: dif.disp_len = (dif.b1[2:0] == 3'h6) ? 2'd2 : 2'd0;
            2'b01: dif.disp_len = 2'd1;
            2'b10: dif.disp_len = 2'd2;
            default: dif.disp_len = 2'd0;
        endcase
        case (dif.form)
            FORM_MODRM: begin
                // Segment forms need a zero ahead of the selector
                if (!((dif.first_op == OP_SEG_LOAD || dif.first_op == OP_SEG_STORE) &&
                    dif.b1[5])) begin
                    dif.op = dif.first_op;
                end
            end
            FORM_IMM_GROUP: begin
                case (dif.b1[5:3])
                    SEL_SUM: dif.op = OP_SUM;
                    SEL_CARRY: dif.op = OP_SUM_WITH_CARRY;
                    SEL_BORROW: dif.op = OP_DIFFERENCE_WITH_BORROW;
                    SEL_DIFF: dif.op = OP_DIFFERENCE;
                    default: dif.op = OP_UNKNOWN;
                endcase
            end
            FORM_UNARY_GROUP: begin
                case (dif.b1[5:3])
                    SEL_SPRODUCT: dif.op = OP_SIGNED_PRODUCT;
                    SEL_SQUOTIENT: dif.op = OP_SIGNED_QUOTIENT;
                    default: dif.op = OP_UNKNOWN;
                endcase
            end
            FORM_SHIFT: begin
                case (dif.b1[5:3])
                    SEL_LSHIFT: dif.op = OP_LEFT_SHIFT;
                    SEL_RSHIFT: dif.op = OP_RIGHT_SHIFT;
                    default: dif.op = OP_UNKNOWN;
                endcase
            end
            FORM_FIXED_B1: begin
                dif.disp_len = 2'd0;
                if (dif.b1 == OPC_FIXED_B1) begin
                    dif.op = dif.first_op;
                end
            end
            default: dif.disp_len = 2'd0;
        endcase
    end

endmodule

// File: bench/cod_queue_model.sv
`timescale 1ns/100ps
module cod_queue_model (
    input wire logic clk_in,
    input wire logic ready_in,
    output logic valid_out,
    output logic [7:0] byte_out
);
    logic [7:0] q[$];
    int stall_pct = 0;
    initial {valid_out, byte_out} = 9'h0;
    // Offer held until taken; idle bus toggles so stale bytes never look valid
    always @(posedge clk_in) begin
        if (valid_out && ready_in) void'(q.pop_front());
        if (!valid_out || ready_in) begin
            if (q.size() > 0 && $urandom_range(99) >= stall_pct) begin
                valid_out <= 1'b1;
                byte_out <= q[0];
            end else begin
                valid_out <= 1'b0;
                byte_out <= ~byte_out;
            end
        end
    end
endmodule

// File: bench/cod_decoder_assertions.sv
`timescale 1ns/100ps
module cod_decoder_assertions
    import cod_pkg::*;
#(
    parameter int ADDR_W = COD_ADDR_W
)(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic [7:0] q_byte_in,
    input wire logic q_valid_in,
    input wire logic q_ready_out,
    input wire logic dec_valid_out,
    input wire logic [COD_RES_W-1:0] dec_result_out
);
    cod_op_type op;
    logic fin;
    assign op = cod_op_type'(dec_result_out[4:0]);
    assign fin = dec_valid_out && !dec_result_out[44];
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_lookup_single: assert property (
        fin && op == OP_TABLE_LOOKUP_BYTE |-> $past(q_byte_in) == 8'hd7
        && dec_result_out[43:41] == 3'h1) else $error("lookup decode");
    a_widen_byte: assert property (
        fin && op == OP_BYTE_TO_WORD_WIDEN |-> $past(q_byte_in) == 8'h98)
        else $error("widen decode");
    a_prod_tail: assert property (
        fin && op == OP_BCD_UNPACKED_PRODUCT_FIX |-> $past(q_byte_in) == 8'h0a
        && dec_result_out[43:41] == 3'h2) else $error("product fix decode");
    a_shift_unit: assert property (
        fin && op inside {OP_LEFT_SHIFT, OP_RIGHT_SHIFT} && !dec_result_out[7]
        |-> dec_result_out[40:33] == 8'h01) else $error("shift count not one");
    a_byte_imm: assert property (
        fin && !dec_result_out[5] && !dec_result_out[6] |-> dec_result_out[32:25] == 8'h00)
        else $error("byte immediate high");
    a_finish_cause: assert property (
        dec_valid_out |-> $past(q_valid_in && q_ready_out)) else $error("finish without byte");
    a_result_holds: assert property (
        !dec_valid_out && $past(rst_n_in) |-> $stable(dec_result_out)) else $error("result moved");
    a_wait_single: assert property (
        $fell(avs_waitrequest_out) |=> avs_waitrequest_out) else $error("wait low too long");
    a_wait_answer: assert property (
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("no bus answer");
endmodule
bind cod_decoder cod_decoder_assertions #(.ADDR_W(ADDR_W)) u_chk (.mclk_in, .rst_n_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
    .avs_readdata_out, .avs_waitrequest_out, .q_byte_in, .q_valid_in, .q_ready_out,
    .dec_valid_out, .dec_result_out);

// File: bench/test_cpu_opcode_decoder_part_one.sv
`timescale 1ns/100ps
module test_cpu_opcode_decoder_part_one;
    import cod_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [4:0] avs_address_in = 5'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out, rd;
    logic avs_waitrequest_out, q_valid_in, q_ready_out, dec_valid_out;
    logic [7:0] q_byte_in, cnt;
    logic [44:0] dec_result_out;
    logic [89:0] sq[$];
    logic [89:0] ee;
    logic [15:0] rb;
    logic [5:0] pat [4] = '{6'h00, 6'h04, 6'h0a, 6'h06};
    cod_op_type ops [4] = '{OP_SUM, OP_SUM_WITH_CARRY, OP_DIFFERENCE, OP_DIFFERENCE_WITH_BORROW};
    int err_count = 0;
    int comparisons = 0;
    int n, k;
    always #5 mclk_in = ~mclk_in;
    cod_decoder dut (.mclk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_byteenable_in(4'hf), .avs_readdata_out, .avs_waitrequest_out,
        .q_byte_in, .q_valid_in, .q_ready_out, .dec_valid_out, .dec_result_out);
    cod_queue_model mdl (.clk_in(mclk_in), .ready_in(q_ready_out), .valid_out(q_valid_in),
        .byte_out(q_byte_in));
    task final_report;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task check(input logic [44:0] s, input logic [44:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        @(posedge mclk_in);
        while (avs_waitrequest_out !== 1'b0) @(posedge mclk_in);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    task rchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    // Expected result: x = {shift count, immediate, flags}; m picks which of them count
    task ins(input logic [31:0] b, input int c, input cod_op_type op,
        input logic [27:0] x = 28'h0, input logic [2:0] m = 3'h0);
        logic [44:0] e, w;
        e = {op == OP_UNKNOWN, 3'(c), x[27:4], 8'h00, x[3:0], op};
        w = {4'hf, {8{m[2]}}, {16{m[1]}}, 8'h00, {4{m[0]}}, 5'h1f};
        for (int i = 0; i < c; i++) mdl.q.push_back(b[8*i+:8]);
        sq.push_back({e & w, w});
    endtask
    task drain;
        for (n = 0; (mdl.q.size() > 0 || sq.size() > 0) && n < 600; n++) @(posedge mclk_in);
        check(sq.size(), 0);
    endtask
    always @(posedge mclk_in) begin
        if (rst_n_in && dec_valid_out === 1'b1) begin
            ee = sq.size() > 0 ? sq.pop_front() : {90{1'b1}};
            check(dec_result_out & ee[44:0], ee[89:45]);
        end
    end
    initial begin
        #100000;
        err_count++;
        final_report;
    end
    initial begin
        void'($urandom(40675));
        repeat (8) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        rchk(REG_CTRL, 32'h1);
        rchk(REG_STATUS, 32'h0);
        rchk(REG_COUNT, 32'h0);
        rchk(5'h1c, 32'h0);
        cnt = 8'($urandom_range(2, 255));
        bus(1'b1, REG_COUNT, {24'h0, cnt});
        rchk(REG_COUNT, {24'h0, cnt});
        ins(32'hd7, 1, OP_TABLE_LOOKUP_BYTE);
        ins(32'h9f, 1, OP_FLAGS_TO_HIGH_ACC);
        ins(32'h9e, 1, OP_HIGH_ACC_TO_FLAGS);
        ins(32'h9c, 1, OP_FLAGS_PUSH);
        ins(32'h37, 1, OP_BCD_UNPACKED_SUM_FIX);
        ins(32'h27, 1, OP_BCD_PACKED_SUM_FIX);
        ins(32'h3f, 1, OP_BCD_UNPACKED_DIFF_FIX);
        ins(32'h2f, 1, OP_BCD_PACKED_DIFF_FIX);
        ins(32'h98, 1, OP_BYTE_TO_WORD_WIDEN);
        ins(32'h99, 1, OP_WORD_TO_PAIR_WIDEN);
        ins(32'hc08e, 2, OP_SEG_LOAD);
        ins(32'hd88c, 2, OP_SEG_STORE);
        ins(32'he08e, 2, OP_UNKNOWN);
        ins(32'h2211868d, 4, OP_EFFECTIVE_ADDRESS_LOAD);
        ins(32'h0fc5, 2, OP_POINTER_LOAD_DATA_SEG);
        ins(32'h07c4, 2, OP_POINTER_LOAD_EXTRA_SEG);
        ins(32'h0ad4, 2, OP_BCD_UNPACKED_PRODUCT_FIX);
        ins(32'h0bd4, 2, OP_UNKNOWN);
        ins(32'h0ad5, 2, OP_BCD_UNPACKED_QUOTIENT_PREP);
        ins(32'he8f7, 2, OP_SIGNED_PRODUCT, 28'h1, 3'h1);
        ins(32'hf9f6, 2, OP_SIGNED_QUOTIENT, 28'h0, 3'h1);
        ins(32'he0d0, 2, OP_LEFT_SHIFT, 28'h0100000, 3'h5);
        ins(32'he8d3, 2, OP_RIGHT_SHIFT, {cnt, 20'h5}, 3'h5);
        ins(32'h12340602, 4, OP_SUM, 28'h8, 3'h1);
        ins(32'h123415, 3, OP_SUM_WITH_CARRY, 28'h12341, 3'h3);
        ins(32'h80d083, 3, OP_SUM_WITH_CARRY, 28'hff803, 3'h3);
        ins(32'h552c, 2, OP_DIFFERENCE, 28'h550, 3'h3);
        ins(32'h1234e881, 4, OP_DIFFERENCE, 28'h12341, 3'h3);
        ins(32'h22111d, 3, OP_DIFFERENCE_WITH_BORROW, 28'h22111, 3'h3);
        ins(32'h7fd880, 3, OP_DIFFERENCE_WITH_BORROW, 28'h7f0, 3'h3);
        mdl.q.push_back(OPC_SEG_LOAD);
        drain;
        rchk(REG_STATUS, 32'h7);
        bus(1'b1, REG_CTRL, 32'h3);
        rchk(REG_STATUS, 32'h1);
        // Random register forms with the queue stalling; d and w land in the flags
        mdl.stall_pct = 40;
        for (int i = 0; i < 24; i++) begin
            k = $urandom_range(0, 3);
            rb = 16'($urandom);
            ins({16'h0, 2'b11, rb[13:8], pat[k], rb[1:0]}, 2, ops[k],
                {24'h0, rb[1], 2'b00, rb[0]}, 3'h1);
        end
        drain;
        rchk(REG_STATUS, 32'h1);
        bus(1'b1, REG_STATUS, 32'h1);
        rchk(REG_STATUS, 32'h0);
        bus(1'b1, REG_CTRL, 32'h0);
        repeat (2) @(posedge mclk_in);
        check(q_ready_out, 1'b0);
        ins(32'h37, 1, OP_BCD_UNPACKED_SUM_FIX);
        repeat (10) @(posedge mclk_in);
        check(sq.size(), 1);
        bus(1'b1, REG_CTRL, 32'h1);
        drain;
        rchk(REG_RES_LO, {27'h0, OP_BCD_UNPACKED_SUM_FIX});
        rchk(REG_RES_HI, 32'h200);
        final_report;
    end
endmodule
